/* hw/sled_cfg.svh */
// timing and code constants for the status led flasher
`ifndef SLED_CFG_SVH
`define SLED_CFG_SVH

`define SLED_CLK_HZ        100000000
`define SLED_PULSE_MS      100
`define SLED_PAUSE_MS      500
`define SLED_TICK_HZ       1000
`define SLED_TICK_DIV_RST  32'h000186A0
`define SLED_PULSE_TICKS   (`SLED_PULSE_MS * `SLED_TICK_HZ / 1000)
`define SLED_PAUSE_TICKS   (`SLED_PAUSE_MS * `SLED_TICK_HZ / 1000)
`define SLED_CODE_OV       3'h1
`define SLED_CODE_IPM      3'h2
`define SLED_CODE_OC       3'h3
`define SLED_CODE_OS       3'h4
`define SLED_CODE_FB       3'h5

`endif

/* hw/sled_pkg.sv */
// types for the status led flasher
package sled_pkg;

	typedef struct packed {
		logic feedback;
		logic overspeed;
		logic overcurrent;
		logic power_module;
		logic bus_overvolt;
	} sled_trip_t;

	typedef struct packed {
		logic red;
		logic green;
	} sled_led_t;

	typedef enum logic [2:0] {
		SLED_OFF,
		SLED_GREEN,
		SLED_BLINK_GREEN,
		SLED_RED,
		SLED_CODE,
		SLED_ALTERNATE
	} sled_mode_t;

	typedef enum logic [1:0] {
		SLED_PH_ON,
		SLED_PH_GAP,
		SLED_PH_PAUSE
	} sled_phase_t;

endpackage : sled_pkg

/* hw/sled_flasher.sv */
// status led driver with latched trip flags and flash codes
`timescale 1ns/1ps
`include "sled_cfg.svh"

// Summary of operation
// - Enabled drive with no error, download or undervoltage shows steady green.
// - During firmware download with no latched error the led blinks green.
// - Disabled drive with no latched error, download or undervoltage shows steady red.
// - An error gives red pulses equal to its code, 0.1 s apart, then a 0.5 s pause, repeated.
// - Bus overvoltage is code 1 and power module trip is code 2.
// - Overcurrent is code 3, overspeed code 4, feedback code 5.
// - With several latched errors the smallest code is shown.
// - A newly arrived smaller code takes over the display at once.
// - Undervoltage with no other error or download alternates red and green.
// - The undervoltage indication follows the bus and clears itself.
// - Undervoltage together with a latched error shows that error's code.
// - After a motor phase short trip, restart is refused until mains is removed.
module sled_flasher (
	input  wire logic                clk,
	input  wire logic                resetn,
	// drive state
	input  wire logic                drive_enabled,
	input  wire logic                fw_download,
	input  wire logic                bus_undervolt,
	input  wire logic                mains_present,
	// trip events, one-cycle or level
	input  wire sled_pkg::sled_trip_t trip_in,
	input  wire logic                phase_short_trip,
	input  wire logic                clear_errors,
	// prescaler control
	input  wire logic [31:0]         tick_div,
	input  wire logic                tick_div_load,
	// outputs
	output sled_pkg::sled_led_t      led,
	output sled_pkg::sled_trip_t     trip_latched,
	output logic [2:0]               error_code,
	output logic                     restart_inhibit,
	output logic                     tick
);

	// ==========================================================
	// prescaler
	// divides clk down to the display tick; every display time
	// is a count of ticks, so one divisor scales them all.
	// a zero divisor would stretch the tick to the full counter range, so it is forced to one.
	// the count restarts only on its own wrap, so a new divisor
	// takes effect at the next wrap at the latest.
	logic [31:0] div_ff;
	logic [31:0] pre_cnt_ff;
	wire         pre_wrap = (pre_cnt_ff >= div_ff - 32'h00000001);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_ff     <= `SLED_TICK_DIV_RST;
			pre_cnt_ff <= 32'h00000000;
			tick       <= 1'b0;
		end else begin
			if (tick_div_load)
				div_ff <= (tick_div == 32'h00000000) ? 32'h00000001 : tick_div;
			pre_cnt_ff <= pre_wrap ? 32'h00000000 : pre_cnt_ff + 32'h00000001;
			tick       <= pre_wrap;
		end
	end

	// ==========================================================
	// trip latches
	// a trip may be a single-cycle pulse, so every flag is held
	// here until software asks for a clear.
	// a trip that lands in the clear cycle survives the clear.
	// the phase-short inhibit is released only by loss of mains.
	sled_pkg::sled_trip_t trips_ff;
	logic                 short_ff;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			trips_ff <= '0;
			short_ff <= 1'b0;
		end else begin
			// set wins over clear
			trips_ff <= (clear_errors ? '0 : trips_ff) | trip_in;
			if (phase_short_trip)
				short_ff <= 1'b1;
			else if (!mains_present)
				short_ff <= 1'b0;
		end
	end

	assign trip_latched    = trips_ff;
	assign restart_inhibit = short_ff;

	// ==========================================================
	// priority encode
	// lowest code wins; zero means no flag is latched
	wire any_err = |trips_ff;
	wire [2:0] nxt_code = trips_ff.bus_overvolt ? `SLED_CODE_OV :
		trips_ff.power_module ? `SLED_CODE_IPM :
		trips_ff.overcurrent  ? `SLED_CODE_OC :
		trips_ff.overspeed    ? `SLED_CODE_OS :
		trips_ff.feedback     ? `SLED_CODE_FB : 3'h0;

	// ==========================================================
	// mode select
	// a latched error outranks everything, undervoltage included;
	// undervoltage is a level and is never latched.
	sled_pkg::sled_mode_t mode;
	assign mode = any_err       ? sled_pkg::SLED_CODE :
		fw_download         ? sled_pkg::SLED_BLINK_GREEN :
		bus_undervolt       ? sled_pkg::SLED_ALTERNATE :
		drive_enabled       ? sled_pkg::SLED_GREEN :
		sled_pkg::SLED_RED;

	// ==========================================================
	// pulse sequencer
	// outside code mode the tick counter still runs and flips
	// tog_ff once per pulse time, for blink and alternate.
	// code_ff parks at 7 outside code mode, so entering code mode
	// always counts as a smaller code and restarts at pulse one.
	// a smaller code restarts at once; a larger one is taken up
	// only at the end of the pause.
	sled_pkg::sled_phase_t phase_ff;
	logic [15:0]           tcnt_ff;
	logic [2:0]            pcnt_ff;
	logic [2:0]            code_ff;
	logic                  tog_ff;
	wire  [15:0]           pulse_t = 16'(`SLED_PULSE_TICKS);
	wire  [15:0]           pause_t = 16'(`SLED_PAUSE_TICKS);
	wire                   t_end   = tick && (tcnt_ff >= pulse_t - 16'h0001);
	wire                   p_end   = tick && (tcnt_ff >= pause_t - 16'h0001);
	wire                   restart = (mode != sled_pkg::SLED_CODE) ||
	                                 (nxt_code < code_ff);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phase_ff <= sled_pkg::SLED_PH_ON;
			tcnt_ff  <= 16'h0000;
			pcnt_ff  <= 3'h0;
			code_ff  <= 3'h0;
			tog_ff   <= 1'b0;
		end else if (restart) begin
			phase_ff <= sled_pkg::SLED_PH_ON;
			tcnt_ff  <= 16'h0000;
			pcnt_ff  <= 3'h1;
			code_ff  <= (mode == sled_pkg::SLED_CODE) ? nxt_code : 3'h7;
			// toggle timing for blink and alternate
			if (t_end)
				tog_ff <= ~tog_ff;
			if (mode == sled_pkg::SLED_CODE)
				tcnt_ff <= 16'h0000;
			else
				tcnt_ff <= t_end ? 16'h0000 : tcnt_ff + {15'h0000, tick};
		end else begin
			case (phase_ff)
				sled_pkg::SLED_PH_ON: begin
					tcnt_ff <= t_end ? 16'h0000 : tcnt_ff + {15'h0000, tick};
					if (t_end)
						phase_ff <= (pcnt_ff >= code_ff) ? sled_pkg::SLED_PH_PAUSE
						                                 : sled_pkg::SLED_PH_GAP;
				end
				sled_pkg::SLED_PH_GAP: begin
					tcnt_ff <= t_end ? 16'h0000 : tcnt_ff + {15'h0000, tick};
					if (t_end) begin
						phase_ff <= sled_pkg::SLED_PH_ON;
						pcnt_ff  <= pcnt_ff + 3'h1;
					end
				end
				sled_pkg::SLED_PH_PAUSE: begin
					tcnt_ff <= p_end ? 16'h0000 : tcnt_ff + {15'h0000, tick};
					if (p_end) begin
						phase_ff <= sled_pkg::SLED_PH_ON;
						pcnt_ff  <= 3'h1;
						code_ff  <= nxt_code;
					end
				end
				default: phase_ff <= sled_pkg::SLED_PH_ON;
			endcase
		end
	end

	// ==========================================================
	// led drive
	// the restart cycle is kept dark so a code change never
	// merges a lit red led into the new first pulse.
	sled_pkg::sled_led_t nxt_led;
	always_comb begin
		nxt_led = '0;
		case (mode)
			sled_pkg::SLED_GREEN:       nxt_led.green = 1'b1;
			sled_pkg::SLED_BLINK_GREEN: nxt_led.green = tog_ff;
			sled_pkg::SLED_RED:         nxt_led.red   = 1'b1;
			sled_pkg::SLED_ALTERNATE: begin
				nxt_led.red   = tog_ff;
				nxt_led.green = ~tog_ff;
			end
			sled_pkg::SLED_CODE:
				nxt_led.red = (phase_ff == sled_pkg::SLED_PH_ON) && !restart;
			default:                    nxt_led = '0;
		endcase
	end

	// led and code are registered so the pins never glitch
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			led        <= '0;
			error_code <= 3'h0;
		end else begin
			led        <= nxt_led;
			error_code <= nxt_code;
		end
	end

endmodule : sled_flasher

/* tb/sled_flasher_checker.sv */
// assertions on the status led flasher ports
`timescale 1ns/1ps
module sled_chk (
	input wire logic                 clk, resetn, drive_enabled, fw_download, bus_undervolt,
	input wire logic                 mains_present, phase_short_trip, clear_errors,
	input wire logic                 restart_inhibit,
	input wire sled_pkg::sled_trip_t trip_in, trip_latched,
	input wire sled_pkg::sled_led_t  led,
	input wire logic [2:0]           error_code
);
	logic calm;
	assign calm = !fw_download && !bus_undervolt && !(|trip_latched);
	// ======
	// properties
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_set; |trip_in |=> &(trip_latched | ~$past(trip_in)); endproperty
	property p_hold; !clear_errors |=> &(trip_latched | ~$past(trip_latched)); endproperty
	property p_clr; clear_errors && !(|trip_in) |=> !(|trip_latched); endproperty
	property p_code; trip_latched.bus_overvolt |=> error_code == 3'h1; endproperty
	property p_inh; phase_short_trip |=> restart_inhibit; endproperty
	property p_grn; (calm && drive_enabled)[*3] |-> led == 2'h1; endproperty
	property p_red; (calm && !drive_enabled)[*3] |-> led == 2'h2; endproperty
	property p_err; (|trip_latched)[*3] |-> !led.green; endproperty
	a_set: assert property (p_set) else $error("trip lost");
	a_hold: assert property (p_hold) else $error("flag dropped");
	a_clr: assert property (p_clr) else $error("clear failed");
	a_code: assert property (p_code) else $error("code not 1");
	a_inh: assert property (p_inh) else $error("no inhibit");
	a_grn: assert property (p_grn) else $error("not green");
	a_red: assert property (p_red) else $error("not red");
	a_err: assert property (p_err) else $error("green in code");
	cover property (trip_latched.feedback && trip_latched.overcurrent);
	cover property (restart_inhibit ##1 !restart_inhibit);
	cover property (bus_undervolt && error_code == 3'h1);
endmodule : sled_chk
bind sled_flasher sled_chk u_chk (.*);

/* tb/testbench.sv */
// self-checking bench for the status led flasher
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin mismatches++; \
	$display("ERROR %s exp %0h got %0h", n, e, a); end end
module testbench;
	logic clk = 0, resetn = 0, drive_enabled = 0, fw_download = 0, bus_undervolt = 0;
	logic mains_present = 1, phase_short_trip = 0, clear_errors = 0, tick_div_load = 0;
	logic [31:0]          tick_div = 32'h2;
	sled_pkg::sled_trip_t trip_in = 5'h00, trip_latched;
	sled_pkg::sled_led_t  led;
	logic [2:0]           error_code;
	logic                 restart_inhibit, tick, pr;
	int mismatches = 0, n_compared = 0, rises, ghi, rhi, ticks, lo, lo_max, hi, hi_max;
	sled_flasher dut (.*);
	initial forever #5 clk = ~clk;
	task automatic give_verdict;
		if (mismatches == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : give_verdict
	task automatic cyc(int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic trip(logic [4:0] v);
		trip_in = v; cyc(1); trip_in = 5'h00; cyc(2);
	endtask : trip
	task automatic clr;
		clear_errors = 1; cyc(1); clear_errors = 0; cyc(4);
	endtask : clr
	// led statistics: red rises, lit cycles, longest dark and lit red runs
	task automatic watch(int n);
		pr = led.red;
		{rises, ghi, rhi, ticks, lo, lo_max, hi, hi_max} = 256'h0;
		repeat (n) begin
			@(negedge clk);
			rises += int'(led.red && !pr); ghi += led.green; rhi += led.red; ticks += tick;
			lo = led.red ? 0 : lo + 1; hi = led.red ? hi + 1 : 0;
			lo_max = lo > lo_max ? lo : lo_max; hi_max = hi > hi_max ? hi : hi_max;
			pr = led.red;
		end
	endtask : watch
	initial begin
		cyc(4);
		resetn = 1;
		tick_div_load = 1; cyc(1); tick_div_load = 0; cyc(3);
		`CHK("led", 2'h2, led)
		drive_enabled = 1; cyc(3);
		`CHK("led", 2'h1, led)
		fw_download = 1; cyc(4); watch(800);
		`CHK("blink", 400, ghi + 1000 * rhi)
		`CHK("ticks", 400, ticks)
		fw_download = 0;
		for (int c = 1; c <= 5; c++) begin
			trip(5'(1 << (c - 1)));
			watch(400 * c + 1100);
			`CHK("code", 3'(c), error_code)
			`CHK("flashes", c, rises)
			`CHK("pause", 1000, lo_max)
			`CHK("pulse", 200, hi_max)
			clr();
		end
		trip(5'h14);
		`CHK("lowest", 3'h3, error_code)
		bus_undervolt = 1; trip(5'h01);
		`CHK("newer", 3'h1, error_code)
		`CHK("latched", 5'h15, trip_latched)
		clr(); watch(800);
		`CHK("alternate", 400400, ghi + 1000 * rhi)
		bus_undervolt = 0; cyc(3);
		`CHK("led", 2'h1, led)
		phase_short_trip = 1; cyc(1); phase_short_trip = 0; clr();
		`CHK("inhibit", 1'h1, restart_inhibit)
		mains_present = 0; cyc(2);
		`CHK("inhibit", 1'h0, restart_inhibit)
		give_verdict();
	end
endmodule : testbench
